// [hdl/tws_bus_if.sv]
/*
 * Two-wire bus carrier: serial clock from the master, open-drain data line.
 * Resolves the wired-AND here from the enables below.
 */
`timescale 1ns/100ps
interface tws_bus_if;
    logic scl;              // Serial clock, driven by the master only
    logic sda_mst_oe;       // Master pulls data low while high
    logic sda_dev_oe;       // Device pulls data low while high
    logic serial_data_pin;  // Resolved line level
    // Wired-AND with pull-up: line low when either side pulls
    assign serial_data_pin = ~(sda_mst_oe | sda_dev_oe);
    modport device (input scl, input serial_data_pin, output sda_dev_oe);
    modport master (output scl, input serial_data_pin, output sda_mst_oe);
endinterface

// [hdl/tws_device.sv]
/*
 * Device end of the two-wire register port: slave with 16-bit registers.
 * Assumes the master keeps clock high and low periods of several clk_i cycles.
 */
// How it works
// - Slave only, open-drain data, master clocks
// - Start then address byte, LSB direction
// - Acknowledge own slave address
// - Write: register address byte, acknowledged
// - Acknowledge every written data byte
// - Registers 16 bits, high byte first
// - Pointer advances after each written word
// - Master ends write with stop/start
// - Read: set pointer, repeated start, read address
// - Bytes shifted out, master acknowledges each
// - Pointer advances after each read word
// - Master not-acknowledge ends read, release line
// - Both lines high means idle
// - Only master makes start and stop
// - Data falls while clock high: start
// - Data rises while clock high: stop
// - Address byte 0xba write, 0xbb read
// - Data changes only while clock low
// - One bit per clock, ack after eight
// - Sender releases in ack slot, receiver pulls
// - Register commits after both bytes
`timescale 1ns/100ps
`include "tws_params.svh"
module tws_device #(
    parameter int NREGS = 256
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Bus side
    tws_bus_if.device        bus,
    // User side: commit pulse of a written register
    output logic             wr_stb_o,
    output tws_pkg::tws_byte_t wr_addr_o,
    output tws_pkg::tws_word_t wr_data_o,
    output logic             busy_o
);
    import tws_pkg::*;

    typedef enum logic [2:0] {
        TWS_IDLE, TWS_ADDR, TWS_REGA, TWS_WDATA, TWS_RDATA, TWS_ACK, TWS_MACK
    } tws_state_t;

    // Register file; no reset, so contents stay undefined until written
    tws_word_t  regs [NREGS];
    tws_state_t state_reg, state_next, ret_reg;
    tws_byte_t  shift_reg;
    tws_byte_t  ptr_reg;
    tws_byte_t  hi_reg;
    logic [2:0] bit_reg;
    logic       lowbyte_reg;
    logic       oe_reg;
    logic       rd_mode_reg;
    logic       wr_stb_reg;
    tws_byte_t  wr_addr_reg;
    tws_word_t  wr_data_reg;
    logic       busy_reg;
    logic       ack_hi_reg;

    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;

    // Both pins are asynchronous to clk_i
    tws_sync u_scl (.clk_i(clk_i), .arst_n_i(arst_n_i), .pin_i(bus.scl),
                    .level_o(scl_lvl), .rise_o(scl_rise), .fall_o(scl_fall));
    tws_sync u_sda (.clk_i(clk_i), .arst_n_i(arst_n_i), .pin_i(bus.serial_data_pin),
                    .level_o(sda_lvl), .rise_o(sda_rise), .fall_o(sda_fall));

    // Bus events; only the master makes these, device merely detects them
    wire start_ev = sda_fall & scl_lvl;
    wire stop_ev  = sda_rise & scl_lvl;
    wire byte_end = scl_rise & (bit_reg == `TWS_BYTE_LAST_BIT);
    wire [7:0] rx_byte = {shift_reg[6:0], sda_lvl};
    wire addr_hit = (rx_byte[7:1] == `TWS_SLAVE_ADDR7);
    wire [15:0] rd_word = regs[ptr_reg];
    wire [7:0] tx_byte = lowbyte_reg ? rd_word[7:0] : rd_word[15:8];

    // The acknowledge slot runs from the fall after bit eight to the fall after
    // the ninth rise; ack_hi_reg marks that the ninth rise has been seen, so the
    // slot is neither cut short nor counted as a data bit of the next byte.
    wire ack_drive   = (state_reg == TWS_ACK) && !ack_hi_reg;
    wire ack_to_read = (state_reg == TWS_ACK) && (ret_reg == TWS_RDATA);

    // Next state on each completed byte or acknowledge slot
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TWS_IDLE:  state_next = TWS_IDLE;
            TWS_ADDR:  if (byte_end) state_next = addr_hit ? TWS_ACK : TWS_IDLE;
            TWS_REGA:  if (byte_end) state_next = TWS_ACK;
            TWS_WDATA: if (byte_end) state_next = TWS_ACK;
            TWS_RDATA: if (byte_end) state_next = TWS_MACK;
            TWS_ACK:   if (scl_fall && ack_hi_reg) state_next = ret_reg;
            TWS_MACK:  if (scl_rise) state_next = sda_lvl ? TWS_IDLE : TWS_RDATA;
            default:   state_next = TWS_IDLE;
        endcase
        if (start_ev) state_next = TWS_ADDR;
        else if (stop_ev) state_next = TWS_IDLE;
    end

    // Protocol state, shifter and bit counter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= TWS_IDLE;
            ret_reg   <= TWS_IDLE;
            shift_reg <= 8'h00;
            bit_reg   <= `TWS_BIT_ZERO;
            ack_hi_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ack_hi_reg <= (state_reg == TWS_ACK) & (ack_hi_reg | scl_rise);
            if (start_ev) begin
                bit_reg <= `TWS_BIT_ZERO;
            end else if (scl_rise && state_reg != TWS_ACK && state_reg != TWS_MACK) begin
                shift_reg <= rx_byte;
                bit_reg   <= bit_reg + 3'h1;
            end
            if (byte_end) begin
                case (state_reg)
                    TWS_ADDR: ret_reg <= (rx_byte[0] == `TWS_DIR_READ) ? TWS_RDATA
                                                                       : TWS_REGA;
                    default:  ret_reg <= rd_mode_reg ? TWS_RDATA : TWS_WDATA;
                endcase
            end
        end
    end

    // Pointer, byte phase and register commit
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_reg     <= `TWS_PTR_RESET;
            hi_reg      <= 8'h00;
            lowbyte_reg <= 1'b0;
            rd_mode_reg <= 1'b0;
            wr_stb_reg  <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= `TWS_REG_RESET;
        end else begin
            wr_stb_reg <= 1'b0;
            if (start_ev) begin
                lowbyte_reg <= 1'b0;                            // Partial word dropped
            end else if (byte_end) begin
                case (state_reg)
                    TWS_ADDR: rd_mode_reg <= rx_byte[0];
                    TWS_REGA: ptr_reg <= rx_byte;
                    TWS_WDATA: begin
                        lowbyte_reg <= ~lowbyte_reg;
                        if (!lowbyte_reg) begin
                            hi_reg <= rx_byte;
                        end else begin
                            regs[ptr_reg] <= {hi_reg, rx_byte};
                            wr_stb_reg    <= 1'b1;
                            wr_addr_reg   <= ptr_reg;
                            wr_data_reg   <= {hi_reg, rx_byte};
                            ptr_reg       <= ptr_reg + `TWS_PTR_STEP;
                        end
                    end
                    TWS_RDATA: begin
                        lowbyte_reg <= ~lowbyte_reg;
                        if (lowbyte_reg) ptr_reg <= ptr_reg + `TWS_PTR_STEP;
                    end
                    default: lowbyte_reg <= lowbyte_reg;
                endcase
            end
        end
    end

    // Line driver: set on clock falls and cleared on start or stop, so data holds while clock high
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oe_reg <= 1'b0;
        end else if (start_ev || stop_ev) begin
            oe_reg <= 1'b0;
        end else if (scl_fall) begin
            // Pull for the ack, then either start a read byte or let go;
            // in the master's ack slot the line is released for its answer
            if (ack_drive) begin
                oe_reg <= 1'b1;
            end else if (ack_to_read) begin
                oe_reg <= ~tx_byte[`TWS_BYTE_LAST_BIT];          // First bit after address ack
            end else if (state_reg == TWS_RDATA) begin
                oe_reg <= ~tx_byte[`TWS_BYTE_LAST_BIT - bit_reg];
            end else begin
                oe_reg <= 1'b0;
            end
        end
    end

    // Busy flag and outputs
    // Busy spans start to stop or master nack; a foreign address drops it at once
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) busy_reg <= 1'b0;
        else busy_reg <= (state_next != TWS_IDLE);
    end

    assign bus.sda_dev_oe = oe_reg;
    assign wr_stb_o  = wr_stb_reg;
    assign wr_addr_o = wr_addr_reg;
    assign wr_data_o = wr_data_reg;
    assign busy_o    = busy_reg;
endmodule

// [hdl/tws_master.sv]
/*
 * Master end: runs one 16-bit register write or read per request.
 * Assumes a single device on the bus and a user that waits for done_o.
 */
`timescale 1ns/100ps
`include "tws_params.svh"
module tws_master #(
    parameter int HALF_CYC = `TWS_SCL_HALF_CYC
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    // Bus side
    tws_bus_if.master          bus,
    // User request
    input  wire logic          req_i,
    input  wire logic          rd_i,
    input  tws_pkg::tws_byte_t addr_i,
    input  tws_pkg::tws_word_t wdata_i,
    // User answer
    output logic               done_o,
    output logic               nack_o,
    output tws_pkg::tws_word_t rdata_o
);
    import tws_pkg::*;

    typedef enum logic [1:0] {TWM_IDLE, TWM_RUN} twm_state_t;
    // Sequencer registers; rs_done_reg marks the repeated start as made
    twm_state_t state_reg;
    logic [6:0] slot_reg, nslot_reg;
    logic [1:0] phase_reg;
    logic [9:0] div_reg;
    logic       scl_reg, oe_reg, done_reg, nack_reg, rd_reg;
    tws_word_t  wdat_reg, rdat_reg;
    tws_byte_t  addr_reg;
    logic       sda_m, sda_s;
    logic       rs_done_reg;

    // Line level is another party's output: two flops before use
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin sda_m <= 1'b1; sda_s <= 1'b1; end
        else begin sda_m <= bus.serial_data_pin; sda_s <= sda_m; end
    end

    // Quarter-bit enable from divider
    wire tick = (div_reg == 10'(HALF_CYC - 1));
    wire [3:0] bidx = 4'(slot_reg % 7'd9);   // Bit in 9-bit group, 8 is the ack slot
    wire [6:0] gidx = slot_reg / 7'd9;
    // Transaction bytes: write = ba,reg,hi,lo ; read = ba,reg,(restart)bb,hi,lo
    wire [7:0] wr_b0 = {`TWS_SLAVE_ADDR7, `TWS_DIR_WRITE};
    wire [7:0] rd_b2 = {`TWS_SLAVE_ADDR7, `TWS_DIR_READ};
    wire [7:0] cur_byte = (gidx == 7'd0) ? wr_b0 : (gidx == 7'd1) ? addr_reg :
                          rd_reg ? rd_b2 : (gidx == 7'd2) ? wdat_reg[15:8] : wdat_reg[7:0];
    wire rx_data = rd_reg && (gidx >= 7'd3) && (bidx != 4'd8);
    wire last_grp = (gidx == (rd_reg ? 7'd4 : 7'd3));
    wire drive0 = (bidx == 4'd8) ? (rx_data ? 1'b0 : (rd_reg && gidx == 7'd3))
                                 : (rx_data ? 1'b0 : ~cur_byte[3'(7 - bidx)]);
    // Extra slot before the read address byte, used once per read
    wire restart = rd_reg && gidx == 7'd2 && bidx == 4'd0 && !rs_done_reg;

    // Sequencer: each bit slot is four half-phases of the clock
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= TWM_IDLE; slot_reg <= 7'd0; phase_reg <= 2'd0; div_reg <= 10'd0;
            scl_reg <= 1'b1; oe_reg <= 1'b0; done_reg <= 1'b0; nack_reg <= 1'b0;
            rd_reg <= 1'b0; wdat_reg <= `TWS_REG_RESET; rdat_reg <= `TWS_REG_RESET;
            addr_reg <= 8'h00; nslot_reg <= 7'd0;
            rs_done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            div_reg  <= tick ? 10'd0 : div_reg + 10'd1;
            if (state_reg == TWM_IDLE) begin
                if (req_i) begin
                    state_reg <= TWM_RUN; rd_reg <= rd_i; addr_reg <= addr_i;
                    wdat_reg <= wdata_i; slot_reg <= 7'd0; phase_reg <= 2'd0;
                    oe_reg <= 1'b1; nack_reg <= 1'b0; nslot_reg <= rd_i ? 7'd45 : 7'd36;
                    div_reg <= 10'd0;                  // Full quarter bit after the start
                    rs_done_reg <= 1'b0;
                end
            end else if (tick) begin
                phase_reg <= phase_reg + 2'd1;
                case (phase_reg)
                    2'd0: begin
                        scl_reg <= 1'b0;
                        if (restart) oe_reg <= 1'b0; // Release for repeated start
                    end
                    2'd1: if (slot_reg == nslot_reg) oe_reg <= 1'b1;
                          else if (!restart) oe_reg <= drive0;
                    2'd2: scl_reg <= 1'b1;
                    default: begin
                        if (slot_reg == nslot_reg) begin
                            oe_reg <= 1'b0; state_reg <= TWM_IDLE; done_reg <= 1'b1; // Stop
                        end else if (restart) begin
                            oe_reg <= 1'b1;                    // Repeated start
                            rs_done_reg <= 1'b1;
                        end else begin
                            if (rx_data) rdat_reg <= {rdat_reg[14:0], sda_s};
                            if (bidx == 4'd8 && !rx_data && !(rd_reg && gidx >= 7'd3) && sda_s)
                                nack_reg <= 1'b1;
                            slot_reg <= slot_reg + 7'd1;
                            if (last_grp && bidx == 4'd8) slot_reg <= nslot_reg;
                        end
                    end
                endcase
            end
        end
    end

    assign bus.scl        = scl_reg;
    assign bus.sda_mst_oe = oe_reg;
    assign done_o  = done_reg;
    assign nack_o  = nack_reg;
    assign rdata_o = rdat_reg;
endmodule

// [hdl/tws_params.svh]
/*
 * Timing counts, address codes and field positions for the two-wire register port.
 * Assumes inclusion by bare name from the device, master and sync files and the sim files.
 */
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_CLK_PERIOD_NS   10
`define TWS_SCL_HALF_NS     400
`define TWS_SCL_HALF_CYC    (`TWS_SCL_HALF_NS / `TWS_CLK_PERIOD_NS)
`define TWS_SLAVE_ADDR7     7'h5d
`define TWS_DIR_WRITE       1'b0
`define TWS_DIR_READ        1'b1
`define TWS_BYTE_LAST_BIT   3'h7
`define TWS_BIT_ZERO        3'h0
`define TWS_REG_RESET       16'h0000
`define TWS_PTR_RESET       8'h00
`define TWS_PTR_STEP        8'h01
`endif

// [hdl/tws_pkg.sv]
/*
 * Shared types for both ends of the two-wire register port.
 * Assumes tws_params.svh is on the include path.
 */
package tws_pkg;
    typedef logic [7:0]  tws_byte_t;
    typedef logic [15:0] tws_word_t;
endpackage

// [hdl/tws_sync.sv]
/*
 * Two-flop synchroniser with edge outputs taken from the second stage onward.
 * Assumes one clock domain on clk_i.
 */
`timescale 1ns/100ps
`include "tws_params.svh"
module tws_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Pin in, clean level and edges out
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    // Only sync_reg reads meta_reg; reset high matches an idle bus
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;
endmodule

// [sim/test_two_wire_register_slave.sv]
/* Bench joining the master and device ends, plus a bit-banged second bus.
   Assumes the design files and tws_params.svh are compiled first. */
`timescale 1ns/100ps
`include "tws_params.svh"
module test_two_wire_register_slave;
    import tws_pkg::*;
    localparam int HB = 10;
    logic        clk_i, arst_n_i, req_i, rd_i, done_o, nack_o, stb1, stb2, ak, bsy1;
    tws_byte_t   addr_i, wa1, wa2, g, a8;
    tws_word_t   wdata_i, rdata_o, wd1, wd2;
    tws_word_t   mem [256];
    logic [15:0] seed;
    logic [31:0] wd32, rd32;
    logic [23:0] q1[$], q2[$];
    int          mismatches, tests_run;
    tws_bus_if if_a();
    tws_bus_if if_b();
    tws_master #(.HALF_CYC(HB)) u_tws_master (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(if_a),
        .req_i(req_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .done_o(done_o),
        .nack_o(nack_o), .rdata_o(rdata_o));
    tws_device u_tws_device (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(if_a), .wr_stb_o(stb1),
        .wr_addr_o(wa1), .wr_data_o(wd1), .busy_o(bsy1));
    tws_device u_tws_device_2 (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(if_b), .wr_stb_o(stb2),
        .wr_addr_o(wa2), .wr_data_o(wd2), .busy_o());
    tws_bus_monitor u_tws_bus_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl(if_a.scl),
        .sda_mst_oe(if_a.sda_mst_oe), .sda_dev_oe(if_a.sda_dev_oe),
        .serial_data_pin(if_a.serial_data_pin));
    // Free-running system clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Collect commit pulses of both devices
    always @(negedge clk_i) begin
        if (stb1 === 1'b1) q1.push_back({wa1, wd1});
        if (stb2 === 1'b1) q2.push_back({wa2, wd2});
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [23:0] take(ref logic [23:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 24'hx;
    endfunction
    task automatic check(input string n, input logic [23:0] e, input logic [23:0] v);
        tests_run++;
        if (v !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic summarize;
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // One request to the master end, then its answer checked
    task automatic xfer(input logic rd, input tws_byte_t a, input tws_word_t wd);
        int i;
        req_i = 1'b1;
        rd_i = rd;
        addr_i = a;
        wdata_i = wd;
        tick(1);
        req_i = 1'b0;
        for (i = 0; i < 5000 && done_o !== 1'b1; i++) tick(1);
        if (i == 5000) begin
            mismatches++;
            summarize();
        end
        check("nack", 24'h0, {23'h0, nack_o});
        if (rd) check("rdata", {8'h0, mem[a]}, {8'h0, rdata_o});
        else check("commit", {a, wd}, take(q1));
        if (!rd) mem[a] = wd;
        tick(4);
        check("busy", 24'h0, {23'h0, bsy1});
    endtask
    // Bit-banged master on the second bus
    task automatic bb_bit(input logic b, output logic s);
        if_b.scl = 1'b0;
        tick(HB);
        if_b.sda_mst_oe = ~b;
        tick(HB);
        if_b.scl = 1'b1;
        tick(HB);
        s = if_b.serial_data_pin;
        tick(HB);
    endtask
    task automatic bb_cond(input logic stop);
        if_b.scl = 1'b0;
        tick(HB);
        if_b.sda_mst_oe = stop;
        tick(HB);
        if_b.scl = 1'b1;
        tick(HB);
        if_b.sda_mst_oe = ~stop;
        tick(HB);
    endtask
    task automatic bb_byte(input tws_byte_t d, input logic last, output tws_byte_t r,
                           output logic a);
        for (int i = 7; i >= 0; i--) bb_bit(d[i], r[i]);
        bb_bit(last, a);
    endtask
    task automatic bb_w(input tws_byte_t d, input logic e);
        bb_byte(d, 1'b1, g, ak);
        check("ack", {23'h0, e}, {23'h0, ak});
    endtask
    // Main sequence
    initial begin
        {arst_n_i, req_i, rd_i, addr_i, wdata_i} = '0;
        if_b.scl = 1'b1;
        if_b.sda_mst_oe = 1'b0;
        mismatches = 0;
        tests_run = 0;
        seed = 16'h9d9c;
        tick(12);
        arst_n_i = 1'b1;
        xfer(1'b0, 8'h00, 16'hffff);
        xfer(1'b0, 8'hff, 16'h0000);
        xfer(1'b1, 8'h00, 16'h0000);
        xfer(1'b1, 8'hff, 16'h0000);
        for (int n = 0; n < 5; n++) begin
            seed = lfsr(seed);
            a8 = seed[7:0];
            seed = lfsr(seed);
            xfer(1'b0, a8, seed);
            xfer(1'b1, a8, 16'h0000);
        end
        bb_cond(1'b0);
        bb_w(8'h5a, 1'b1);
        bb_w(8'hba, 1'b1);
        bb_cond(1'b0);
        bb_w(8'hba, 1'b0);
        bb_w(8'h40, 1'b0);
        bb_w(8'h12, 1'b0);
        bb_cond(1'b0);
        bb_cond(1'b1);
        check("partial", 24'h0, {23'h0, q2.size() != 0});
        seed = lfsr(seed);
        wd32[31:16] = seed;
        seed = lfsr(seed);
        wd32[15:0] = seed;
        bb_cond(1'b0);
        bb_w(8'hba, 1'b0);
        bb_w(8'hfe, 1'b0);
        for (int k = 0; k < 4; k++) bb_w(wd32[31 - 8 * k -: 8], 1'b0);
        bb_cond(1'b1);
        check("burst0", {8'hfe, wd32[31:16]}, take(q2));
        check("burst1", {8'hff, wd32[15:0]}, take(q2));
        bb_cond(1'b0);
        bb_w(8'hba, 1'b0);
        bb_w(8'hfe, 1'b0);
        bb_cond(1'b0);
        bb_w(8'hbb, 1'b0);
        for (int k = 0; k < 4; k++) begin
            bb_byte(8'hff, k == 3, g, ak);
            rd32 = {rd32[23:0], g};
        end
        check("release", 24'h0, {23'h0, if_b.sda_dev_oe});
        bb_cond(1'b1);
        check("rd0", {8'h0, wd32[31:16]}, {8'h0, rd32[31:16]});
        check("rd1", {8'h0, wd32[15:0]}, {8'h0, rd32[15:0]});
        summarize();
    end
endmodule

// [sim/tws_bus_monitor.sv]
/* Wire checker for the two-wire register port.
   Assumes the bench ties it to the bus that joins master and device. */
`timescale 1ns/100ps
`include "tws_params.svh"
module tws_bus_monitor (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Bus lines
    input  wire logic scl,
    input  wire logic sda_mst_oe,
    input  wire logic sda_dev_oe,
    input  wire logic serial_data_pin
);
    logic       scl_q, pin_q, first_q, rd_q, nack_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    // Bus events seen from the sampled lines
    wire rise_w  = scl & ~scl_q;
    wire start_w = scl & scl_q & pin_q & ~serial_data_pin;
    wire stop_w  = scl & scl_q & ~pin_q & serial_data_pin;
    wire ack_w   = rise_w & (cnt_q == 4'h8);
    wire own_w   = (sh_q[7:1] == `TWS_SLAVE_ADDR7);
    // Bit counter, byte shifter and read state
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {scl_q, pin_q, first_q, rd_q, nack_q} <= 5'h1c;
            cnt_q <= 4'h0;
            sh_q  <= 8'h00;
        end else begin
            scl_q <= scl;
            pin_q <= serial_data_pin;
            if (start_w | stop_w) begin
                cnt_q   <= 4'h0;
                first_q <= 1'b1;
                nack_q  <= 1'b0;
            end else if (ack_w) begin
                cnt_q   <= 4'h0;
                first_q <= 1'b0;
                rd_q    <= first_q ? sh_q[0] : rd_q;
                nack_q  <= nack_q | (~first_q & rd_q & serial_data_pin);
            end else if (rise_w) begin
                cnt_q <= cnt_q + 4'h1;
                sh_q  <= {sh_q[6:0], serial_data_pin};
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_addr_ack: assert property (ack_w && first_q && own_w |-> !serial_data_pin)
        else $error("own address not acknowledged");
    chk_data_ack: assert property (ack_w && !first_q && !rd_q |-> !serial_data_pin)
        else $error("written byte not acknowledged");
    chk_read_release: assert property (ack_w && !first_q && rd_q |-> !sda_dev_oe)
        else $error("device held data in master ack slot");
    chk_nack_quiet: assert property (nack_q |-> !sda_dev_oe)
        else $error("device drove after master nack");
    chk_dev_hold_high: assert property (scl && scl_q |-> $stable(sda_dev_oe))
        else $error("device data moved while clock high");
    chk_dev_rise_low: assert property ($rose(sda_dev_oe) |-> !scl && !scl_q)
        else $error("device pulled data outside clock low");
    chk_start_master: assert property (start_w |-> sda_mst_oe && !sda_dev_oe)
        else $error("start not made by master");
    chk_stop_master: assert property (stop_w |-> $past(sda_mst_oe) && !sda_dev_oe)
        else $error("stop not made by master");
    cover property (ack_w && !first_q && !rd_q);
    cover property (nack_q);
    cover property (start_w && scl_q && !first_q);
endmodule
